// ===== pwm_cfg.svh
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH

// ----------------------------------------
// Clock rates
// ----------------------------------------
`define SYS_CLK_MHZ 250
`define OSC_CLK_MHZ 25
`define TICK_DIV (`SYS_CLK_MHZ / `OSC_CLK_MHZ)

// ----------------------------------------
// Register map, byte addresses
// ----------------------------------------
`define CTRL_BASE_OFS 12'h000
`define STATUS_OFS 12'h010

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define THR_LSB 0
`define THR_MSB 7
`define INC_LSB 8
`define INC_MSB 23
`define UPD_BIT 30
`define EN_BIT 31
`define CTRL_RST 32'h0000_0000

`endif

// ===== pwm_pkg.sv
package pwm_pkg;

  typedef logic [15:0] incr_t;
  typedef logic [7:0] thresh_t;
  typedef logic [11:0] addr_t;
  typedef logic [31:0] word_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ANSWER = 2'b10
  } apb_state_t;

endpackage : pwm_pkg

// ===== pwm_channel.sv
`timescale 1ns/1ns
`include "pwm_cfg.svh"

module pwm_channel (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic tick,
  input wire logic enable,
  input wire logic updReq,
  input wire pwm_pkg::incr_t incIn,
  input wire pwm_pkg::thresh_t thrIn,
  // Results
  output logic applyNow,
  output logic modOut
);
  import pwm_pkg::*;

  // ----------------------------------------
  // Accumulator
  // ----------------------------------------
  logic [15:0] cnt_q;
  incr_t inc_q;
  thresh_t thr_q;
  logic [16:0] sum;
  logic wrap;
  logic idleLoad;
  logic [15:0] cntNext;
  logic outNext;

  assign sum = {1'b0, cnt_q} + {1'b0, inc_q};
  assign wrap = enable & tick & sum[16];
  // No period runs, so the counter already sits at a boundary
  assign idleLoad = !enable || (inc_q == '0);
  assign applyNow = updReq & (wrap | idleLoad);
  assign cntNext = !enable ? 16'h0000 : (tick ? sum[15:0] : cnt_q);
  // Top byte only: finer increments cannot gain duty resolution
  assign outNext = enable && (inc_q != '0) && !wrap
    && (cntNext[15:8] >= thr_q);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cnt_q <= 16'h0000;
      inc_q <= '0;
      thr_q <= '0;
      modOut <= 1'b0;
    end
    else
    begin
      cnt_q <= cntNext;
      modOut <= outNext;
      if (applyNow)
      begin
        inc_q <= incIn;
        thr_q <= thrIn;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  wrap_low_a: assert property (wrap |=> !modOut)
    else $error("output not low after wrap");
  above_thr_a: assert property ($rose(modOut) |-> cnt_q[15:8] >= thr_q)
    else $error("output rose below threshold");
  held_high_a: assert property (modOut && !$past(wrap) && enable && !tick
    && !applyNow |=> modOut)
    else $error("output dropped inside period");
  acc_step_a: assert property (enable && tick |=> cnt_q == 16'($past(cnt_q)
    + $past(inc_q)))
    else $error("counter did not add increment");
  zero_inc_a: assert property (inc_q == '0 |=> !modOut)
    else $error("zero increment output not low");
  disabled_a: assert property (!enable |=> !modOut && cnt_q == 16'h0000)
    else $error("disabled channel not idle");
  load_edge_a: assert property ($changed(inc_q) |-> $past(wrap || idleLoad))
    else $error("settings loaded mid period");

  wrap_c: cover property (wrap ##[2:1000] modOut);
  load_c: cover property (enable && applyNow && !idleLoad);

endmodule : pwm_channel

// ===== pulse_width_generator.sv
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "pwm_cfg.svh"

module pulse_width_generator #(
  parameter int N_CH = 2,
  parameter int TICK_DIV = `TICK_DIV
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire pwm_pkg::addr_t paddr,
  input wire pwm_pkg::word_t pwdata,
  input wire logic [3:0] pstrb,
  output pwm_pkg::word_t prdata,
  output logic pready,
  output logic pslverr,
  // Modulated outputs
  output logic [N_CH-1:0] modulated_output
);
  import pwm_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic word_t mergeBytes(input word_t oldW, input word_t newW,
    input logic [3:0] strb);
    word_t res;
    res = oldW;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[8*b +: 8] = newW[8*b +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  function automatic logic ctrlHit(input addr_t a, input int idx);
    return a == (`CTRL_BASE_OFS + addr_t'(4 * idx));
  endfunction : ctrlHit

  // ----------------------------------------
  // Oscillator rate tick
  // ----------------------------------------
  logic [7:0] tickCnt_q;
  // Cycles since the last tick, kept only for the rate check
  logic [7:0] gapCnt_q;
  logic tick_q;
  logic tickWrap;

  assign tickWrap = tickCnt_q == 8'(TICK_DIV - 1);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tickCnt_q <= 8'h00;
      gapCnt_q <= 8'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      tickCnt_q <= tickWrap ? 8'h00 : tickCnt_q + 8'h01;
      gapCnt_q <= tick_q ? 8'h01 : gapCnt_q + 8'h01;
      tick_q <= tickWrap;
    end
  end

  // ----------------------------------------
  // APB handshake
  // ----------------------------------------
  apb_state_t state_q;
  apb_state_t state_d;
  logic accessSeen;
  logic wrEn;
  logic ctrlSel;
  logic statSel;
  logic [N_CH-1:0] hitVec;
  word_t readData;

  assign accessSeen = psel & penable;
  // Writes land at the edge where pready is sampled high
  assign wrEn = (state_q == ST_ANSWER) & accessSeen & pwrite;
  assign statSel = paddr == `STATUS_OFS;
  assign ctrlSel = |hitVec;

  always_comb
  begin
    case (state_q)
      ST_IDLE: state_d = accessSeen ? ST_ANSWER : ST_IDLE;
      ST_ANSWER: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      state_q <= state_d;
      pready <= (state_q == ST_IDLE) & accessSeen;
      pslverr <= (state_q == ST_IDLE) & accessSeen & !(ctrlSel | statSel);
      prdata <= (state_q == ST_IDLE) & accessSeen & !pwrite ? readData
        : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Channel control registers
  // ----------------------------------------
  incr_t inc_q [N_CH];
  thresh_t thr_q [N_CH];
  logic [N_CH-1:0] en_q;
  logic [N_CH-1:0] upd_q;
  logic [N_CH-1:0] apply;
  logic [N_CH-1:0] outBits;
  word_t ctrlWord [N_CH];

  for (genvar i = 0; i < N_CH; i++)
  begin : g_ch
    word_t newWord;
    logic upd_d;

    assign hitVec[i] = ctrlHit(paddr, i);
    assign ctrlWord[i] = {en_q[i], upd_q[i], 6'h00, inc_q[i], thr_q[i]};
    assign newWord = mergeBytes(ctrlWord[i], pwdata, pstrb);
    // A request written while one is applied stays pending
    assign upd_d = (wrEn & hitVec[i]) ? newWord[`UPD_BIT]
      : (apply[i] ? 1'b0 : upd_q[i]);

    always_ff @(posedge sys_clk)
    begin
      if (rst)
      begin
        inc_q[i] <= 16'(`CTRL_RST >> `INC_LSB);
        thr_q[i] <= 8'(`CTRL_RST >> `THR_LSB);
        en_q[i] <= 1'(`CTRL_RST >> `EN_BIT);
        upd_q[i] <= 1'(`CTRL_RST >> `UPD_BIT);
      end
      else
      begin
        upd_q[i] <= upd_d;
        if (wrEn & hitVec[i])
        begin
          inc_q[i] <= newWord[`INC_MSB:`INC_LSB];
          thr_q[i] <= newWord[`THR_MSB:`THR_LSB];
          en_q[i] <= newWord[`EN_BIT];
        end
      end
    end

    // Each instance owns its accumulator and pin
    pwm_channel u_chan (
      .sys_clk(sys_clk),
      .rst(rst),
      .tick(tick_q),
      .enable(en_q[i]),
      .updReq(upd_q[i]),
      .incIn(inc_q[i]),
      .thrIn(thr_q[i]),
      .applyNow(apply[i]),
      .modOut(outBits[i])
    );

    upd_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(upd_q[i]) |-> $past(apply[i]) || $past(wrEn & hitVec[i]))
      else $error("update request cleared without cause");
    upd_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      upd_q[i] && !apply[i] && !(wrEn & hitVec[i]) |=> upd_q[i])
      else $error("pending update lost");
  end

  assign modulated_output = outBits;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb
  begin
    readData = 32'h0000_0000;
    if (statSel)
    begin
      readData = {16'h0000, 8'(upd_q), 8'(outBits)};
    end
    for (int k = 0; k < N_CH; k++)
    begin
      if (hitVec[k])
      begin
        readData = ctrlWord[k];
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  tick_rate_a: assert property (tick_q |-> gapCnt_q == 8'(TICK_DIV))
    else $error("tick spacing too short");
  tick_gap_a: assert property (tickWrap |=> tick_q)
    else $error("tick missing after divider wrap");
  apb_answer_a: assert property (state_q == ST_IDLE && accessSeen |=> pready)
    else $error("no answer one cycle after access");
  apb_single_a: assert property (pready |=> !pready)
    else $error("answer held too long");

  write_c: cover property (wrEn && ctrlSel);
  read_c: cover property (pready && !pwrite && statSel);
  bad_c: cover property (pready && pslverr);

endmodule : pulse_width_generator

// ===== pulse_width_generator_tb_top.sv
`timescale 1ns/1ns
`include "pwm_cfg.svh"

module pulse_width_generator_tb_top;
  import pwm_pkg::*;
  // Short tick divider keeps the long periods affordable
  localparam int TD = 2;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  addr_t paddr = 12'h000;
  word_t pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  word_t prdata;
  logic pready;
  logic pslverr;
  logic [1:0] modulated_output;
  int miscompares = 0;
  int totalChecks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0001_24B7;
  word_t rd;
  logic err;
  incr_t inc [2];
  thresh_t thr [2];

  always #2 sys_clk = ~sys_clk;

  pulse_width_generator #(.N_CH(2), .TICK_DIV(TD)) dut (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .modulated_output(modulated_output));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic word_t ctrl(input logic en, input logic upd, input incr_t i, input thresh_t t);
    word_t w;
    w = 32'h0000_0000;
    w[`EN_BIT] = en;
    w[`UPD_BIT] = upd;
    w[`INC_MSB:`INC_LSB] = i;
    w[`THR_MSB:`THR_LSB] = t;
    return w;
  endfunction : ctrl

  // High clocks in one period; counter top byte against threshold
  function automatic int exp_high(input incr_t i, input thresh_t t);
    int hi;
    hi = 0;
    if (i == 16'h0000)
      return 0;
    for (int k = 0; k < 65536 / i; k++)
      if (((k * i) >> 8) >= t)
        hi++;
    return hi * TD;
  endfunction : exp_high

  task automatic check(input word_t got, input word_t exp);
    totalChecks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask : check

  // Request held until pready is sampled high; answer taken at that edge
  task automatic apb(input logic wr, input addr_t a, input word_t d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
    begin
      @(posedge sys_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic measure(input int ch, input int clocks, output int hi);
    hi = 0;
    repeat (clocks)
    begin
      @(negedge sys_clk);
      if (modulated_output[ch] === 1'b1)
        hi++;
    end
  endtask : measure

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles >= 60000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    int hi;
    int per;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    for (int a = 0; a < 3; a++)
    begin
      apb(1'b0, addr_t'(a == 2 ? `STATUS_OFS : `CTRL_BASE_OFS + 4 * a), 32'h0000_0000);
      check(rd, 32'h0000_0000);
      check({31'h0000_0000, err}, 32'h0000_0000);
    end
    apb(1'b1, 12'h020, 32'hFFFF_FFFF);
    check({31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b0, 12'h020, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check({31'h0000_0000, err}, 32'h0000_0001);
    for (int it = 0; it < 6; it++)
    begin
      for (int c = 0; c < 2; c++)
      begin
        inc[c] = 16'h0100 << (xs() % 6);
        thr[c] = 8'(xs()) | 8'h01;
      end
      // Corners: longest period with top threshold, and zero increment
      if (it == 0)
      begin
        inc[0] = 16'h0100;
        thr[0] = 8'hFF;
        inc[1] = 16'h0000;
      end
      for (int c = 0; c < 2; c++)
      begin
        apb(1'b1, addr_t'(4 * c), ctrl(it > 0, 1'b0, inc[c], thr[c]));
        apb(1'b1, addr_t'(4 * c), ctrl(it > 0, 1'b1, inc[c], thr[c]));
        if (it == 0)
          apb(1'b1, addr_t'(4 * c), ctrl(1'b1, 1'b1, inc[c], thr[c]));
      end
      repeat (1100) @(posedge sys_clk);
      for (int c = 0; c < 2; c++)
      begin
        apb(1'b0, addr_t'(4 * c), 32'h0000_0000);
        check(rd, ctrl(1'b1, 1'b0, inc[c], thr[c]));
        measure(c, 1024, hi);
        per = (inc[c] == 16'h0000) ? 1024 : 65536 / inc[c] * TD;
        check(32'(hi), 32'(exp_high(inc[c], thr[c]) * (1024 / per)));
      end
      apb(1'b0, `STATUS_OFS, 32'h0000_0000);
      check({24'h00_0000, rd[15:8]}, 32'h0000_0000);
    end
    for (int c = 0; c < 2; c++)
      apb(1'b1, addr_t'(4 * c), ctrl(1'b0, 1'b0, 16'h1000, 8'h10));
    repeat (4) @(posedge sys_clk);
    measure(0, 512, hi);
    check(32'(hi), 32'h0000_0000);
    measure(1, 512, hi);
    check(32'(hi), 32'h0000_0000);
    apb(1'b0, `STATUS_OFS, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    // Byte strobe: only the threshold byte may change
    pstrb <= 4'h1;
    apb(1'b1, `CTRL_BASE_OFS, 32'hFFFF_FFAB);
    pstrb <= 4'hF;
    apb(1'b0, `CTRL_BASE_OFS, 32'h0000_0000);
    check(rd, ctrl(1'b0, 1'b0, 16'h1000, 8'hAB));
    report_and_stop();
  end

endmodule : pulse_width_generator_tb_top
